// [rtl/hbad_consts.svh]
// Constants for the host bus address decode front end
`ifndef HBAD_CONSTS_SVH
`define HBAD_CONSTS_SVH

`define HBAD_WIN_MSB      15
`define HBAD_WIN_LSB      4
`define HBAD_SEL_MSB      3
`define HBAD_SEL_LSB      1
`define HBAD_LANES_ALL    4'hF
`define HBAD_LANES_LOW    4'h3
`define HBAD_OE_OFF       2'h3
`define HBAD_DATA_ZERO    32'h0000_0000
`define HBAD_ADDR_ZERO    15'h0000
`define HBAD_SEL_ZERO     3'h0
`define HBAD_LANES_NONE   4'h0
`define HBAD_CLK_NS       20
`define HBAD_RST_MIN_NS   100
`define HBAD_RST_CYC      3'((`HBAD_RST_MIN_NS + `HBAD_CLK_NS - 1) / `HBAD_CLK_NS)
`define HBAD_CNT_ZERO     3'h0
`define HBAD_CNT_ONE      3'h1

`endif

// [rtl/hbad_pkg.sv]
// Types for the host bus address decode front end
package hbad_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } hbad_state_e;

    typedef struct packed {
        logic [15:1] addr;
        logic        qual_n;
    } hbad_addr_s;

    typedef struct packed {
        logic [2:0] reg_sel;
        logic [3:0] lane_en;
        logic       burst;
        logic       write;
    } hbad_req_s;

endpackage : hbad_pkg

// [rtl/hbad_reset_filter.sv]
// Glitch filter on the device reset input
`timescale 1ns/1ps
`include "hbad_consts.svh"

module hbad_reset_filter (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic reset_in,
    output logic      dev_reset
);

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic       dev_reset_r;

    // Count consecutive high samples, saturate at the minimum width
    assign cnt_nxt = !reset_in ? `HBAD_CNT_ZERO :
                     (cnt_r == `HBAD_RST_CYC) ? cnt_r :
                     cnt_r + `HBAD_CNT_ONE;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r       <= `HBAD_CNT_ZERO;
            dev_reset_r <= 1'b0;
        end else begin
            cnt_r       <= cnt_nxt;
            dev_reset_r <= (cnt_nxt == `HBAD_RST_CYC);
        end
    end

    assign dev_reset = dev_reset_r;

    property p_rst_long;
        @(posedge mclk) disable iff (!rst_b)
        reset_in [*5] |=> dev_reset;
    endproperty
    a_rst_long: assert property (p_rst_long)
        else $error("Reset held 100 ns not taken");

    property p_rst_short;
        @(posedge mclk) disable iff (!rst_b)
        (!reset_in ##1 reset_in [*4] ##1 !reset_in) |=> !dev_reset;
    endproperty
    a_rst_short: assert property (p_rst_short)
        else $error("Short reset pulse was not filtered");

endmodule : hbad_reset_filter

// [rtl/hbad_top.sv]
// Host bus address qualify, latch, decode and lane select front end
`timescale 1ns/1ps
`include "hbad_consts.svh"

module hbad_top (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    input  wire logic                 reset_in,
    input  wire logic [15:1]          host_addr,
    input  wire logic                 address_qualifier_n,
    input  wire logic [3:0]           byte_lane_enable_n,
    input  wire logic                 data_path_select_n,
    input  wire logic                 address_latch_strobe_n,
    input  wire logic                 sync_cycle_frame_n,
    input  wire logic                 write_not_read,
    input  wire logic                 addr_latch_mode,
    input  wire logic                 bus_16bit,
    input  wire logic [11:0]          io_base,
    input  wire logic [31:0]          data_in,
    output logic      [31:0]          data_out,
    output logic      [1:0]           data_oe_n,
    output logic                      local_device_hit_n,
    output logic                      dev_reset,
    output hbad_pkg::hbad_req_s       reg_req,
    output logic                      reg_valid,
    output logic                      reg_rd_strobe,
    output logic                      reg_wr_strobe,
    output logic      [31:0]          reg_wdata,
    input  wire logic [31:0]          reg_rdata
);

    hbad_pkg::hbad_state_e state_r;
    hbad_pkg::hbad_state_e state_nxt;
    hbad_pkg::hbad_addr_s  adr_r;
    hbad_pkg::hbad_addr_s  adr_live;
    hbad_pkg::hbad_addr_s  adr_eff;
    hbad_pkg::hbad_req_s   req_r;
    hbad_pkg::hbad_req_s   req_nxt;
    logic                  strobe_prev_r;
    logic                  strobe_rise;
    logic                  live_hit;
    logic                  eff_hit;
    logic                  dp_sel;
    logic                  start;
    logic [3:0]            lanes;
    logic [31:0]           data_out_r;
    logic [31:0]           wdata_r;
    logic                  rd_strobe_r;
    logic                  wr_strobe_r;

    // Window compare of the upper address bits against the base
    function automatic logic win_match(input logic [15:1] a, input logic [11:0] base);
        win_match = (a[`HBAD_WIN_MSB:`HBAD_WIN_LSB] == base);
    endfunction : win_match

    hbad_reset_filter u_reset_filter (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .reset_in  (reset_in),
        .dev_reset (dev_reset)
    );

    // Address capture on the rising strobe edge
    assign strobe_rise = !strobe_prev_r && address_latch_strobe_n;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_prev_r <= 1'b1;
            adr_r         <= '{addr: `HBAD_ADDR_ZERO, qual_n: 1'b1};
        end else begin
            strobe_prev_r <= address_latch_strobe_n;
            if (strobe_rise) begin
                adr_r <= adr_live;
            end
        end
    end

    // Decode paths: latched (addr_latch_mode) or live for internal use, live for the hit output
    assign adr_live  = '{addr: host_addr, qual_n: address_qualifier_n};
    assign adr_eff   = addr_latch_mode ? adr_r : adr_live;
    assign live_hit  = !address_qualifier_n && win_match(host_addr, io_base);
    assign local_device_hit_n = !live_hit;
    assign eff_hit   = !adr_eff.qual_n && win_match(adr_eff.addr, io_base);
    assign dp_sel    = !data_path_select_n;

    // Lane selection; burst forces all lanes, narrow bus keeps the low half
    assign lanes = (dp_sel ? `HBAD_LANES_ALL : ~byte_lane_enable_n)
                   & (bus_16bit ? `HBAD_LANES_LOW : `HBAD_LANES_ALL);

    // Cycle start needs a frame plus a hit or the data path select
    assign start = (state_r == hbad_pkg::ST_IDLE) && !sync_cycle_frame_n
                   && (eff_hit || dp_sel);

    assign req_nxt = '{reg_sel: adr_eff.addr[`HBAD_SEL_MSB:`HBAD_SEL_LSB],
                       lane_en: lanes,
                       burst:   dp_sel,
                       write:   write_not_read};

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hbad_pkg::ST_IDLE: begin
                if (start) begin
                    state_nxt = write_not_read ? hbad_pkg::ST_WRITE : hbad_pkg::ST_READ;
                end
            end
            hbad_pkg::ST_READ, hbad_pkg::ST_WRITE: begin
                if (sync_cycle_frame_n) begin
                    state_nxt = hbad_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = hbad_pkg::ST_IDLE;
            end
        endcase
        if (dev_reset) begin
            state_nxt = hbad_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= hbad_pkg::ST_IDLE;
            req_r   <= '{reg_sel: `HBAD_SEL_ZERO, lane_en: `HBAD_LANES_NONE,
                         burst: 1'b0, write: 1'b0};
        end else begin
            state_r <= state_nxt;
            if (start && !dev_reset) begin
                req_r <= req_nxt;
            end
        end
    end

    // Read data, write data and strobes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_r  <= `HBAD_DATA_ZERO;
            wdata_r     <= `HBAD_DATA_ZERO;
            rd_strobe_r <= 1'b0;
            wr_strobe_r <= 1'b0;
        end else begin
            rd_strobe_r <= start && !write_not_read && !dev_reset;
            wr_strobe_r <= (state_r == hbad_pkg::ST_WRITE) && sync_cycle_frame_n
                           && !dev_reset;
            if (state_nxt == hbad_pkg::ST_READ) begin
                data_out_r <= reg_rdata;
            end
            if ((state_r == hbad_pkg::ST_WRITE) && !sync_cycle_frame_n) begin
                wdata_r <= data_in;
            end
        end
    end

    assign data_out      = data_out_r;
    assign data_oe_n[0]  = (state_r != hbad_pkg::ST_READ);
    assign data_oe_n[1]  = (state_r != hbad_pkg::ST_READ) || bus_16bit;
    assign reg_req       = req_r;
    assign reg_valid     = (state_r != hbad_pkg::ST_IDLE);
    assign reg_rd_strobe = rd_strobe_r;
    assign reg_wr_strobe = wr_strobe_r;
    assign reg_wdata     = wdata_r;

    property p_qual_block;
        @(posedge mclk) disable iff (!rst_b)
        (state_r == hbad_pkg::ST_IDLE && adr_eff.qual_n && data_path_select_n)
            |=> (state_r == hbad_pkg::ST_IDLE);
    endproperty
    a_qual_block: assert property (p_qual_block)
        else $error("Cycle started while qualifier high");

    property p_hit_live;
        @(posedge mclk) disable iff (!rst_b)
        address_qualifier_n |-> local_device_hit_n;
    endproperty
    a_hit_live: assert property (p_hit_live)
        else $error("Hit output asserted with qualifier high");

    property p_sel;
        @(posedge mclk) disable iff (!rst_b)
        $rose(reg_valid)
            |-> (reg_req.reg_sel == $past(adr_eff.addr[`HBAD_SEL_MSB:`HBAD_SEL_LSB]));
    endproperty
    a_sel: assert property (p_sel)
        else $error("Register select not taken from address");

    property p_burst;
        @(posedge mclk) disable iff (!rst_b)
        (start && dp_sel && !bus_16bit && !dev_reset)
            |=> (reg_req.lane_en == `HBAD_LANES_ALL) && reg_req.burst;
    endproperty
    a_burst: assert property (p_burst)
        else $error("Burst access did not use all lanes");

    property p_oe_read;
        @(posedge mclk) disable iff (!rst_b)
        (state_r != hbad_pkg::ST_READ) |-> (data_oe_n == `HBAD_OE_OFF);
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("Data bus driven outside a read");

    property p_narrow;
        @(posedge mclk) disable iff (!rst_b)
        bus_16bit |-> data_oe_n[1] && (lanes[3:2] == 2'h0);
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("Upper lanes used in 16-bit system");

    property p_latch;
        @(posedge mclk) disable iff (!rst_b)
        strobe_rise |=> (adr_r.addr == $past(host_addr))
                        && (adr_r.qual_n == $past(address_qualifier_n));
    endproperty
    a_latch: assert property (p_latch)
        else $error("Address not captured on strobe rise");

    property p_dir;
        @(posedge mclk) disable iff (!rst_b)
        (start && !dev_reset) |=> (state_r == ($past(write_not_read) ?
                                   hbad_pkg::ST_WRITE : hbad_pkg::ST_READ));
    endproperty
    a_dir: assert property (p_dir)
        else $error("Cycle direction wrong");

    property p_frame_end;
        @(posedge mclk) disable iff (!rst_b)
        (state_r == hbad_pkg::ST_WRITE && sync_cycle_frame_n && !dev_reset)
            |=> (state_r == hbad_pkg::ST_IDLE) && reg_wr_strobe ##1 !reg_wr_strobe;
    endproperty
    a_frame_end: assert property (p_frame_end)
        else $error("Write cycle end not tracked");

    property p_lanes;
        @(posedge mclk) disable iff (!rst_b)
        (start && !dp_sel && !bus_16bit && !dev_reset)
            |=> (reg_req.lane_en == ~$past(byte_lane_enable_n)) && !reg_req.burst;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("Lane enables not taken from the host");

    property p_hit_win;
        @(posedge mclk) disable iff (!rst_b)
        (host_addr[`HBAD_WIN_MSB:`HBAD_WIN_LSB] != io_base) |-> local_device_hit_n;
    endproperty
    a_hit_win: assert property (p_hit_win)
        else $error("Hit output asserted outside the window");

    property p_grant;
        @(posedge mclk) disable iff (!rst_b)
        (state_r == hbad_pkg::ST_IDLE && !sync_cycle_frame_n && !data_path_select_n
         && !dev_reset) |=> reg_valid;
    endproperty
    a_grant: assert property (p_grant)
        else $error("Data path select did not start a cycle");

    property p_live;
        @(posedge mclk) disable iff (!rst_b)
        (state_r == hbad_pkg::ST_IDLE && !addr_latch_mode && !sync_cycle_frame_n
         && !local_device_hit_n && !dev_reset) |=> reg_valid;
    endproperty
    a_live: assert property (p_live)
        else $error("Live address hit did not start a cycle");

    property p_latched;
        @(posedge mclk) disable iff (!rst_b)
        ($rose(reg_valid) && $past(addr_latch_mode))
            |-> (reg_req.reg_sel == $past(adr_r.addr[`HBAD_SEL_MSB:`HBAD_SEL_LSB]));
    endproperty
    a_latched: assert property (p_latched)
        else $error("Register select not taken from captured address");

    property p_rst_hold;
        @(posedge mclk) disable iff (!rst_b)
        dev_reset |=> (state_r == hbad_pkg::ST_IDLE) && !reg_rd_strobe && !reg_wr_strobe;
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("Cycle active while filtered reset high");

    property p_rd_pulse;
        @(posedge mclk) disable iff (!rst_b)
        reg_rd_strobe |=> !reg_rd_strobe;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("Read strobe longer than one cycle");

    property p_rd_data;
        @(posedge mclk) disable iff (!rst_b)
        (state_nxt == hbad_pkg::ST_READ) |=> (data_out == $past(reg_rdata));
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("Read data not taken from the core");

    property p_req_hold;
        @(posedge mclk) disable iff (!rst_b)
        (state_r != hbad_pkg::ST_IDLE) |=> $stable(reg_req);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("Request changed inside a cycle");

endmodule : hbad_top

// [verif/hbad_host_model.sv]
// Host bus master model driving synchronous cycles into the front end
`timescale 1ns/1ps

module hbad_host_model (
    input  wire logic        mclk,
    output logic      [15:1] host_addr,
    output logic             address_qualifier_n,
    output logic      [3:0]  byte_lane_enable_n,
    output logic             data_path_select_n,
    output logic             address_latch_strobe_n,
    output logic             sync_cycle_frame_n,
    output logic             write_not_read,
    output logic      [31:0] data_in
);
    initial begin
        host_addr              = 15'h0000;
        address_qualifier_n    = 1'b1;
        byte_lane_enable_n     = 4'hF;
        data_path_select_n     = 1'b1;
        address_latch_strobe_n = 1'b1;
        sync_cycle_frame_n     = 1'b1;
        write_not_read         = 1'b0;
        data_in                = 32'hFFFF_FFFF;
    end

    task automatic start(input logic [15:1] a, input logic q, input logic [3:0] be,
                         input logic dps, input logic wnr, input logic [31:0] wd);
        @(posedge mclk);
        host_addr           <= a;
        address_qualifier_n <= q;
        byte_lane_enable_n  <= be;
        data_path_select_n  <= dps;
        write_not_read      <= wnr;
        data_in             <= wnr ? wd : 32'hFFFF_FFFF;
        sync_cycle_frame_n  <= 1'b0;
    endtask : start

    task automatic finish();
        @(posedge mclk);
        sync_cycle_frame_n  <= 1'b1;
        byte_lane_enable_n  <= 4'hF;
        data_path_select_n  <= 1'b1;
        address_qualifier_n <= 1'b1;
        // Released data lines float to the pull-up level
        data_in             <= 32'hFFFF_FFFF;
    endtask : finish

    task automatic latch(input logic [15:1] a, input logic q);
        @(posedge mclk);
        address_latch_strobe_n <= 1'b0;
        host_addr              <= a;
        address_qualifier_n    <= q;
        @(posedge mclk);
        address_latch_strobe_n <= 1'b1;
        @(posedge mclk);
        // Live lines move on once the rising strobe is taken
        host_addr              <= ~a;
        address_qualifier_n    <= 1'b1;
    endtask : latch
endmodule : hbad_host_model

// [verif/hbad_top_bench.sv]
// Self-checking bench for the host bus address decode front end
`timescale 1ns/1ps

module hbad_top_bench;
    localparam logic [15:1] HIT_A = {12'h0A3, 3'h5};
    logic                mclk;
    logic                rst_b;
    logic                reset_in;
    logic                addr_latch_mode;
    logic                bus_16bit;
    logic [31:0]         reg_rdata;
    logic [15:1]         host_addr;
    logic                qual_n;
    logic [3:0]          be_n;
    logic                dps_n;
    logic                ads_n;
    logic                frame_n;
    logic                wnr;
    logic [31:0]         data_in;
    logic [31:0]         data_out;
    logic [1:0]          data_oe_n;
    logic                hit_n;
    logic                dev_reset;
    hbad_pkg::hbad_req_s reg_req;
    logic                reg_valid;
    logic                rd_stb;
    logic                wr_stb;
    logic [31:0]         reg_wdata;
    int                  bad_count;
    int                  num_checks;
    int                  cycles;

    hbad_top i_hbad_top (.mclk(mclk), .rst_b(rst_b), .reset_in(reset_in), .host_addr(host_addr),
        .address_qualifier_n(qual_n), .byte_lane_enable_n(be_n), .data_path_select_n(dps_n),
        .address_latch_strobe_n(ads_n), .sync_cycle_frame_n(frame_n), .write_not_read(wnr),
        .addr_latch_mode(addr_latch_mode), .bus_16bit(bus_16bit), .io_base(12'h0A3),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .local_device_hit_n(hit_n), .dev_reset(dev_reset), .reg_req(reg_req),
        .reg_valid(reg_valid), .reg_rd_strobe(rd_stb), .reg_wr_strobe(wr_stb),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    hbad_host_model i_hbad_host_model (.mclk(mclk), .host_addr(host_addr),
        .address_qualifier_n(qual_n), .byte_lane_enable_n(be_n), .data_path_select_n(dps_n),
        .address_latch_strobe_n(ads_n), .sync_cycle_frame_n(frame_n), .write_not_read(wnr),
        .data_in(data_in));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic edge1();
        @(posedge mclk);
        #1;
    endtask : edge1

    task automatic t_filter();
        @(posedge mclk);
        reset_in <= 1'b1;
        repeat (4) @(posedge mclk);
        reset_in <= 1'b0;
        edge1();
        chk(dev_reset, 1'b0);
        @(posedge mclk);
        reset_in <= 1'b1;
        repeat (4) edge1();
        chk(dev_reset, 1'b0);
        @(posedge mclk);
        reset_in <= 1'b0;
        #1;
        chk(dev_reset, 1'b1);
        edge1();
        chk(dev_reset, 1'b0);
        $display("reset filter test done");
    endtask : t_filter

    task automatic t_read(input logic b16);
        @(posedge mclk);
        bus_16bit <= b16;
        reg_rdata <= 32'h1234_5678;
        i_hbad_host_model.start(HIT_A, 1'b0, 4'hA, 1'b1, 1'b0, 32'h0000_0000);
        edge1();
        chk(hit_n, 1'b0);
        chk(reg_valid, 1'b1);
        chk(reg_req.reg_sel, 3'h5);
        chk(reg_req.lane_en, b16 ? 4'h1 : 4'h5);
        chk(reg_req.write, 1'b0);
        chk(data_oe_n, b16 ? 2'b10 : 2'b00);
        chk(rd_stb, 1'b1);
        chk(data_out, 32'h1234_5678);
        edge1();
        chk(rd_stb, 1'b0);
        i_hbad_host_model.finish();
        edge1();
        chk({reg_valid, data_oe_n}, 3'b011);
        @(posedge mclk);
        bus_16bit <= 1'b0;
        $display("read test done");
    endtask : t_read

    task automatic t_write();
        i_hbad_host_model.start(HIT_A, 1'b0, 4'h0, 1'b1, 1'b1, 32'hA5C3_0F96);
        edge1();
        chk({reg_valid, reg_req.write, reg_req.lane_en}, 6'h3F);
        chk(data_oe_n, 2'b11);
        i_hbad_host_model.finish();
        edge1();
        chk({reg_valid, wr_stb}, 2'b01);
        chk(reg_wdata, 32'hA5C3_0F96);
        edge1();
        chk(wr_stb, 1'b0);
        $display("write test done");
    endtask : t_write

    task automatic t_burst();
        i_hbad_host_model.start({12'h000, 3'h2}, 1'b1, 4'hF, 1'b0, 1'b0, 32'h0000_0000);
        edge1();
        chk({reg_valid, reg_req.burst, reg_req.lane_en}, 6'h3F);
        i_hbad_host_model.finish();
        edge1();
        chk(reg_valid, 1'b0);
        $display("burst test done");
    endtask : t_burst

    task automatic t_refuse(input logic [15:1] a, input logic q);
        i_hbad_host_model.start(a, q, 4'h0, 1'b1, 1'b0, 32'h0000_0000);
        edge1();
        chk({hit_n, reg_valid, rd_stb}, 3'b100);
        i_hbad_host_model.finish();
        edge1();
        $display("refuse test done");
    endtask : t_refuse

    task automatic t_latch();
        @(posedge mclk);
        addr_latch_mode <= 1'b1;
        i_hbad_host_model.latch({12'h0A3, 3'h6}, 1'b0);
        i_hbad_host_model.start(~{12'h0A3, 3'h6}, 1'b1, 4'hC, 1'b1, 1'b0, 32'h0000_0000);
        edge1();
        chk({hit_n, reg_valid, reg_req.reg_sel}, 5'h1E);
        chk(reg_req.lane_en, 4'h3);
        i_hbad_host_model.finish();
        edge1();
        @(posedge mclk);
        addr_latch_mode <= 1'b0;
        $display("latch test done");
    endtask : t_latch

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            $display("[FAIL] %0t run timed out", $time);
            end_sim();
        end
    end

    initial begin
        rst_b           = 1'b0;
        reset_in        = 1'b0;
        addr_latch_mode = 1'b0;
        bus_16bit       = 1'b0;
        reg_rdata       = 32'h0000_0000;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_filter();
        t_read(1'b0);
        t_read(1'b1);
        t_write();
        t_burst();
        t_refuse(HIT_A, 1'b1);
        t_refuse({12'h0A2, 3'h5}, 1'b0);
        t_latch();
        end_sim();
    end
endmodule : hbad_top_bench
